/* bench/mgmt_master_model.sv */
// Management controller model that drives the register port.
// Assumes one clock; reads return data in the cycle after the strobe.
`timescale 1ns/1ps
module mgmt_master_model (
    input  wire logic        clk_sys_i,
    output logic      [4:0]  reg_addr_o,
    output logic      [15:0] reg_wdata_o,
    output logic             reg_wr_o,
    output logic             reg_rd_o,
    input  wire logic [15:0] reg_rdata_i
);
    localparam logic [15:0] RSVD_MASK = 16'h0001 << phy_vendor_regs_pkg::SM_RSVD_ONE_BIT;

    // Idle bus at time zero
    initial begin
        reg_addr_o  = 5'h00;
        reg_wdata_o = 16'h0000;
        reg_wr_o    = 1'b0;
        reg_rd_o    = 1'b0;
    end

    // One-cycle write; reserved one-bit always written as one
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk_sys_i);
        reg_addr_o  <= a;
        reg_wdata_o <= (a == phy_vendor_regs_pkg::IDX_SPECIAL_MODES) ? (d | RSVD_MASK) : d;
        reg_wr_o    <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_o    <= 1'b0;
        reg_wdata_o <= ~d; // Released data does not keep its value
    endtask

    // One-cycle read; reserved one-bit ignored on return
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(posedge clk_sys_i);
        reg_addr_o <= a;
        reg_rd_o   <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_o   <= 1'b0;
        #1;
        d = reg_rdata_i;
        if (a == phy_vendor_regs_pkg::IDX_SPECIAL_MODES) begin
            d = d & ~RSVD_MASK;
        end
    endtask
endmodule

/* bench/tb_phy_vendor_mode_status_regs.sv */
// Self-checking bench for the vendor mode/status register bank.
// Assumes the management model drives the register port; 25 MHz clock.
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin error_cnt++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_phy_vendor_mode_status_regs;
    typedef struct packed {
        logic [4:0]  idx;
        logic [15:0] wd;
        logic [15:0] exp;
        logic [15:0] msk;
    } row_type;

    logic                                 clk_sys_i;
    logic                                 rst_i      = 1'b1;
    logic                                 soft_rst_i = 1'b0;
    logic                                 isolate_i  = 1'b0;
    logic [2:0]                           mode_strap_i = 3'b110;
    logic                                 addr_strap_i = 1'b1;
    logic [4:0]                           reg_addr;
    logic [15:0]                          reg_wdata;
    logic                                 reg_wr;
    logic                                 reg_rd;
    logic [15:0]                          reg_rdata;
    phy_vendor_regs_pkg::line_status_type line_s = 5'b01000;
    phy_vendor_regs_pkg::ctrl_type        ctrl_s;
    logic                                 energy_o;
    logic                                 loop_o;
    logic                                 mdix_o;
    logic [4:0]                           seed_o;
    int                                   error_cnt = 0;
    int                                   compares  = 0;
    row_type                              rows [7];

    // Clock at 40 ns period
    initial begin
        clk_sys_i = 1'b0;
        forever #20 clk_sys_i = ~clk_sys_i;
    end

    mgmt_master_model m (.clk_sys_i(clk_sys_i), .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata),
        .reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .reg_rdata_i(reg_rdata));

    phy_vendor_mode_status_regs #(.ENERGY_TIMEOUT_CYC(50), .CNT_W(4)) uut (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .soft_rst_i(soft_rst_i), .isolate_i(isolate_i),
        .mode_strap_i(mode_strap_i), .addr_strap_i(addr_strap_i), .reg_addr_i(reg_addr),
        .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .line_i(line_s),
        .reg_rdata_o(reg_rdata), .ctrl_o(ctrl_s), .line_energy_present_o(energy_o),
        .far_loopback_active_o(loop_o), .crossover_mdix_o(mdix_o), .scrambler_seed_o(seed_o));

    // Counts, verdict and end of run
    task automatic print_verdict();
        $display("compares=%0d error_cnt=%0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask

    task automatic rchk(input logic [4:0] a, input logic [15:0] e, input logic [15:0] mk);
        logic [15:0] d;
        m.rd(a, d);
        `CHK(d & mk, e)
    endtask

    task automatic hard_reset();
        @(posedge clk_sys_i);
        rst_i <= 1'b1;
        cyc(10);
        rst_i <= 1'b0;
        cyc(2);
    endtask

    // One error burst, optionally closed by an end of packet
    task automatic err_burst(input bit pe);
        @(posedge clk_sys_i);
        line_s.symbol_error <= 1'b1;
        cyc(3);
        line_s.symbol_error <= 1'b0;
        if (pe) begin
            line_s.packet_end <= 1'b1;
            cyc(3);
            line_s.packet_end <= 1'b0;
        end
        cyc(6);
    endtask

    // Hang guard
    initial begin
        #(20000 * 40);
        error_cnt++;
        print_verdict();
    end

    initial begin
        rows = '{'{5'h11, 16'h2241, 16'h2243, 16'hffff}, '{5'h11, 16'h0000, 16'h0002, 16'hffff},
                 '{5'h12, 16'h40ab, 16'h00ab, 16'h00ff}, '{5'h1b, 16'ha800, 16'ha800, 16'hffff},
                 '{5'h1b, 16'h0000, 16'h0000, 16'hffff}, '{5'h1a, 16'hffff, 16'h0000, 16'hffff},
                 '{5'h05, 16'hffff, 16'h0000, 16'hffff}};
        hard_reset();
        // Defaults after hardware reset
        rchk(5'h11, 16'h0002, 16'hffff);
        rchk(5'h12, 16'h00c1, 16'h00ff);
        rchk(5'h1b, 16'h0000, 16'hffff);
        rchk(5'h1a, 16'h0000, 16'hffff);
        `CHK(seed_o, 5'h01)
        `CHK(energy_o, 1'b1)
        // Write then read back each row
        foreach (rows[i]) begin
            m.wr(rows[i].idx, rows[i].wd);
            rchk(rows[i].idx, rows[i].exp, rows[i].msk);
        end
        `CHK(seed_o, 5'h0b)
        `CHK(ctrl_s.transceiver_mode, 3'b101)
        // Energy flag timeout
        line_s.valid_energy <= 1'b0;
        cyc(36);
        rchk(5'h11, 16'h0002, 16'h0002);
        cyc(40);
        rchk(5'h11, 16'h0000, 16'h0002);
        `CHK(energy_o, 1'b0)
        // Software reset keeps only the marked fields
        m.wr(5'h11, 16'h2240);
        m.wr(5'h1b, 16'ha800);
        @(posedge clk_sys_i);
        soft_rst_i <= 1'b1;
        @(posedge clk_sys_i);
        soft_rst_i <= 1'b0;
        cyc(2);
        rchk(5'h11, 16'h0000, 16'hffff);
        rchk(5'h12, 16'h00ab, 16'h00ff);
        rchk(5'h1b, 16'h0800, 16'hffff);
        `CHK(ctrl_s.heartbeat_test_disable, 1'b1)
        line_s.valid_energy <= 1'b1;
        // Manual pair selection
        m.wr(5'h1b, 16'h8000);
        cyc(2);
        `CHK(mdix_o, 1'b0)
        m.wr(5'h1b, 16'ha000);
        cyc(2);
        `CHK(mdix_o, 1'b1)
        // Far loopback with isolate set, then in 10 mode
        line_s.link_is_100 <= 1'b1;
        isolate_i <= 1'b1;
        m.wr(5'h11, 16'h0200);
        cyc(6);
        `CHK(loop_o, 1'b1)
        line_s.link_is_100 <= 1'b0;
        cyc(6);
        `CHK(loop_o, 1'b0)
        // Receive polarity status
        line_s.rx_polarity_reversed <= 1'b1;
        cyc(6);
        rchk(5'h1b, 16'h0010, 16'h0010);
        line_s.rx_polarity_reversed <= 1'b0;
        // Error counter: held in 10 mode, once per packet, wraps
        err_burst(1'b1);
        rchk(5'h1a, 16'h0000, 16'hffff);
        line_s.link_is_100 <= 1'b1;
        cyc(4);
        err_burst(1'b0);
        err_burst(1'b0);
        err_burst(1'b1);
        rchk(5'h1a, 16'h0001, 16'hffff);
        rchk(5'h1a, 16'h0001, 16'hffff);
        repeat (15) err_burst(1'b1);
        rchk(5'h1a, 16'h0000, 16'hffff);
        // Hardware reset sets energy flag and reloads straps
        err_burst(1'b1);
        line_s.valid_energy <= 1'b0;
        cyc(80);
        hard_reset();
        rchk(5'h11, 16'h0002, 16'hffff);
        rchk(5'h12, 16'h00c1, 16'h00ff);
        rchk(5'h1a, 16'h0000, 16'hffff);
        `CHK(energy_o, 1'b1)
        print_verdict();
    end
endmodule

/* rtl/phy_vendor_mode_status_regs.sv */
// Vendor mode/status management registers of a 10/100 transceiver.
// Assumes a one-cycle register port from the management frame decoder
// and line status from asynchronous receive logic.
// What this block does
// - Energy-detect power-down enable, reset zero
// - Far loopback retransmits received packets, 100 only
// - Far loopback ignores the isolate control bit
// - Bit 6 selects primary or alternate interrupts
// - Energy flag clears after 256ms silence
// - Energy flag: hard reset sets, soft keeps
// - Transceiver mode writable, default from straps
// - Address is management address and scrambler seed
// - Address default from strap, writable afterwards
// - Counter counts invalid symbols in 100 mode
// - Counter advances once per packet at most
// - Counter wraps to zero at maximum
// - Reset clears counter; reads leave it
// - Counter holds in 10BASE-T mode
// - Bit 15 disables auto crossover, bit 13 decides
// - Manual pair select: zero straight, one crossed
// - Bit 11 disables heartbeat test, reset zero
// - Bit 4 reports 10BASE-T receive polarity
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
module phy_vendor_mode_status_regs #(
    parameter longint ENERGY_TIMEOUT_CYC = phy_vendor_regs_pkg::ENERGY_TIMEOUT_CYC,
    parameter int     CNT_W              = 16
) (
    input  wire logic                                 clk_sys_i,
    input  wire logic                                 rst_i,
    input  wire logic                                 soft_rst_i,
    input  wire logic                                 isolate_i,
    input  wire logic [2:0]                           mode_strap_i,
    input  wire logic                                 addr_strap_i,
    input  wire logic [4:0]                           reg_addr_i,
    input  wire logic [15:0]                          reg_wdata_i,
    input  wire logic                                 reg_wr_i,
    input  wire logic                                 reg_rd_i,
    input  wire phy_vendor_regs_pkg::line_status_type line_i,
    output logic      [15:0]                          reg_rdata_o,
    output phy_vendor_regs_pkg::ctrl_type             ctrl_o,
    output logic                                      line_energy_present_o,
    output logic                                      far_loopback_active_o,
    output logic                                      crossover_mdix_o,
    output logic      [4:0]                           scrambler_seed_o
);

    localparam logic [31:0] TMO_LAST = 32'(ENERGY_TIMEOUT_CYC - 1);

    // All state of the block
    typedef struct packed {
        phy_vendor_regs_pkg::ctrl_type        ctrl;
        logic                                 spare0;
        logic                                 rsvd_one;
        logic                                 energy;
        logic [31:0]                          silence_cnt;
        logic [CNT_W-1:0]                     sym_err_cnt;
        logic                                 pkt_counted;
        logic                                 strap_pending;
        phy_vendor_regs_pkg::line_status_type sync1;
        phy_vendor_regs_pkg::line_status_type sync2;
        logic [15:0]                          rdata;
        logic                                 loop_act;
        logic                                 mdix;
    } state_type;

    state_type state_r;
    state_type state_nxt;

    // Register index match
    function automatic logic hit(input logic [4:0] a, input logic [4:0] idx);
        hit = (a == idx);
    endfunction

    // Next-state logic
    always_comb begin
        logic wr_mcs;
        logic wr_sm;
        logic wr_xs;
        phy_vendor_regs_pkg::line_status_type ls;
        wr_mcs = 1'b0;
        wr_sm  = 1'b0;
        wr_xs  = 1'b0;
        ls     = '0;
        state_nxt = state_r;
        ls = state_r.sync2;
        // Two-stage synchroniser for line status
        state_nxt.sync1 = line_i;
        state_nxt.sync2 = state_r.sync1;

        wr_mcs = reg_wr_i && hit(reg_addr_i, phy_vendor_regs_pkg::IDX_MODE_CTRL_STATUS);
        wr_sm  = reg_wr_i && hit(reg_addr_i, phy_vendor_regs_pkg::IDX_SPECIAL_MODES);
        wr_xs  = reg_wr_i && hit(reg_addr_i, phy_vendor_regs_pkg::IDX_XOVER_SQE_POL);

        // Mode control/status writes
        if (wr_mcs) begin
            state_nxt.ctrl.energy_detect_powerdown_en =
                reg_wdata_i[phy_vendor_regs_pkg::MCS_EDPD_BIT];
            state_nxt.ctrl.line_side_loopback_en =
                reg_wdata_i[phy_vendor_regs_pkg::MCS_FARLOOP_BIT];
            state_nxt.ctrl.alternate_interrupt_select =
                reg_wdata_i[phy_vendor_regs_pkg::MCS_ALTERNATE_INTERRUPT_SELECT_BIT];
            state_nxt.spare0 = reg_wdata_i[phy_vendor_regs_pkg::MCS_SPARE_BIT];
        end

        // Special modes writes
        if (wr_sm) begin
            state_nxt.rsvd_one = reg_wdata_i[phy_vendor_regs_pkg::SM_RSVD_ONE_BIT];
            state_nxt.ctrl.transceiver_mode =
                reg_wdata_i[phy_vendor_regs_pkg::SM_MODE_LSB +: 3];
            state_nxt.ctrl.phy_management_address =
                reg_wdata_i[phy_vendor_regs_pkg::SM_ADDR_LSB +: 5];
        end

        // Crossover / heartbeat writes
        if (wr_xs) begin
            state_nxt.ctrl.auto_crossover_disable =
                reg_wdata_i[phy_vendor_regs_pkg::XS_AMDIX_DIS_BIT];
            state_nxt.ctrl.manual_pair_select =
                reg_wdata_i[phy_vendor_regs_pkg::XS_PAIR_SEL_BIT];
            state_nxt.ctrl.heartbeat_test_disable =
                reg_wdata_i[phy_vendor_regs_pkg::XS_SQE_OFF_BIT];
        end

        // Straps captured on the first edge after hardware reset release
        if (state_r.strap_pending) begin
            state_nxt.ctrl.transceiver_mode       = mode_strap_i;
            state_nxt.ctrl.phy_management_address = {4'h0, addr_strap_i};
            state_nxt.strap_pending = 1'b0;
        end

        // Energy silence timer
        if (ls.valid_energy) begin
            state_nxt.silence_cnt = '0;
            state_nxt.energy      = 1'b1;
        end else if (state_r.silence_cnt >= TMO_LAST) begin
            state_nxt.energy = 1'b0;
        end else begin
            state_nxt.silence_cnt = state_r.silence_cnt + 32'h1;
        end

        // Symbol error counter, once per packet, 100 mode only
        if (ls.link_is_100) begin
            if (ls.symbol_error && !state_r.pkt_counted) begin
                state_nxt.sym_err_cnt = state_r.sym_err_cnt + 1'b1;
                state_nxt.pkt_counted = 1'b1;
            end
            if (ls.packet_end) begin
                state_nxt.pkt_counted = 1'b0;
            end
        end

        // Software reset: restore defaults except no-soft-reset fields
        if (soft_rst_i) begin
            state_nxt.ctrl.energy_detect_powerdown_en = 1'b0;
            state_nxt.ctrl.line_side_loopback_en      = 1'b0;
            state_nxt.ctrl.alternate_interrupt_select = 1'b0;
            state_nxt.ctrl.auto_crossover_disable     = 1'b0;
            state_nxt.ctrl.manual_pair_select         = 1'b0;
            state_nxt.spare0                          = 1'b0;
            state_nxt.sym_err_cnt = CNT_W'(phy_vendor_regs_pkg::RST_SYM_ERR_CNT);
            state_nxt.pkt_counted = 1'b0;
            // Energy flag, mode, address, heartbeat kept
        end

        // Far loopback ignores isolate
        state_nxt.loop_act = state_r.ctrl.line_side_loopback_en && ls.link_is_100;
        // Pair select
        state_nxt.mdix = state_r.ctrl.auto_crossover_disable
                         && state_r.ctrl.manual_pair_select;

        // Read mux; reads have no side effects
        state_nxt.rdata = 16'h0000;
        if (reg_rd_i) begin
            case (reg_addr_i)
                phy_vendor_regs_pkg::IDX_MODE_CTRL_STATUS: begin
                    state_nxt.rdata[phy_vendor_regs_pkg::MCS_EDPD_BIT] =
                        state_r.ctrl.energy_detect_powerdown_en;
                    state_nxt.rdata[phy_vendor_regs_pkg::MCS_FARLOOP_BIT] =
                        state_r.ctrl.line_side_loopback_en;
                    state_nxt.rdata[phy_vendor_regs_pkg::MCS_ALTERNATE_INTERRUPT_SELECT_BIT] =
                        state_r.ctrl.alternate_interrupt_select;
                    state_nxt.rdata[phy_vendor_regs_pkg::MCS_ENERGY_BIT] = state_r.energy;
                    state_nxt.rdata[phy_vendor_regs_pkg::MCS_SPARE_BIT] = state_r.spare0;
                end
                phy_vendor_regs_pkg::IDX_SPECIAL_MODES: begin
                    state_nxt.rdata[phy_vendor_regs_pkg::SM_RSVD_ONE_BIT] = state_r.rsvd_one;
                    state_nxt.rdata[phy_vendor_regs_pkg::SM_MODE_LSB +: 3] =
                        state_r.ctrl.transceiver_mode;
                    state_nxt.rdata[phy_vendor_regs_pkg::SM_ADDR_LSB +: 5] =
                        state_r.ctrl.phy_management_address;
                end
                phy_vendor_regs_pkg::IDX_SYMBOL_ERR_CNT: begin
                    state_nxt.rdata = 16'(state_r.sym_err_cnt);
                end
                phy_vendor_regs_pkg::IDX_XOVER_SQE_POL: begin
                    state_nxt.rdata[phy_vendor_regs_pkg::XS_AMDIX_DIS_BIT] =
                        state_r.ctrl.auto_crossover_disable;
                    state_nxt.rdata[phy_vendor_regs_pkg::XS_PAIR_SEL_BIT] =
                        state_r.ctrl.manual_pair_select;
                    state_nxt.rdata[phy_vendor_regs_pkg::XS_SQE_OFF_BIT] =
                        state_r.ctrl.heartbeat_test_disable;
                    state_nxt.rdata[phy_vendor_regs_pkg::XS_RX_POLARITY_REVERSED_BIT] =
                        ls.rx_polarity_reversed;
                end
                default: begin
                    state_nxt.rdata = 16'h0000;
                end
            endcase
        end
    end

    // State register; hardware reset restores every default
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            state_r               <= '0;
            state_r.energy        <= phy_vendor_regs_pkg::RST_ENERGY_PRESENT;
            state_r.rsvd_one      <= phy_vendor_regs_pkg::RST_RSVD_ONE;
            state_r.strap_pending <= 1'b1;
            state_r.sym_err_cnt   <= CNT_W'(phy_vendor_regs_pkg::RST_SYM_ERR_CNT);
        end else begin
            state_r <= state_nxt;
        end
    end

    // Outputs straight from flip-flops
    assign reg_rdata_o           = state_r.rdata;
    assign ctrl_o                = state_r.ctrl;
    assign line_energy_present_o = state_r.energy;
    assign far_loopback_active_o = state_r.loop_act;
    assign crossover_mdix_o      = state_r.mdix;
    assign scrambler_seed_o      = state_r.ctrl.phy_management_address;

    // Assertions
    a_cnt_holds_10: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (!state_r.sync2.link_is_100 && !soft_rst_i) |=> $stable(state_r.sym_err_cnt))
        else $error("symbol counter moved in 10 mode");
    a_cnt_once_pkt: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (state_r.pkt_counted && !state_r.sync2.packet_end && !soft_rst_i)
        |=> $stable(state_r.sym_err_cnt))
        else $error("counter advanced twice in one packet");
    a_cnt_wraps: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        ($past(state_r.sym_err_cnt) == '1 && state_r.sym_err_cnt != $past(state_r.sym_err_cnt)
         && !$past(soft_rst_i)) |-> state_r.sym_err_cnt == '0)
        else $error("counter did not wrap");
    a_energy_drop: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (state_r.silence_cnt >= TMO_LAST && !state_r.sync2.valid_energy) |=> !state_r.energy)
        else $error("energy flag did not fall");
    a_energy_soft: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (soft_rst_i && !state_r.sync2.valid_energy && state_r.silence_cnt < TMO_LAST)
        |=> $stable(state_r.energy))
        else $error("soft reset changed energy flag");
    a_mode_soft: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (soft_rst_i && !reg_wr_i && !state_r.strap_pending)
        |=> ($stable(state_r.ctrl.transceiver_mode)
             && $stable(state_r.ctrl.phy_management_address)
             && $stable(state_r.ctrl.heartbeat_test_disable)
             && !state_r.ctrl.energy_detect_powerdown_en))
        else $error("soft reset handling");
    a_strap_load: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (state_r.strap_pending && !rst_i)
        |=> state_r.ctrl.transceiver_mode == $past(mode_strap_i))
        else $error("mode strap not loaded");
    a_mdix_sel: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        !state_r.ctrl.auto_crossover_disable |=> !crossover_mdix_o)
        else $error("manual pairing with auto crossover on");
    a_read_data: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (reg_rd_i && reg_addr_i == phy_vendor_regs_pkg::IDX_SYMBOL_ERR_CNT)
        |=> reg_rdata_o == 16'($past(state_r.sym_err_cnt)))
        else $error("counter read mismatch");

endmodule

/* rtl/phy_vendor_regs_pkg.sv */
// Package for the vendor mode/status register bank.
// Assumes a 16-bit management register port with 5-bit register index.
package phy_vendor_regs_pkg;

    // Register indices
    localparam logic [4:0] IDX_MODE_CTRL_STATUS = 5'h11;
    localparam logic [4:0] IDX_SPECIAL_MODES    = 5'h12;
    localparam logic [4:0] IDX_SYMBOL_ERR_CNT   = 5'h1a;
    localparam logic [4:0] IDX_XOVER_SQE_POL    = 5'h1b;

    // Mode control/status field positions
    localparam int MCS_EDPD_BIT      = 13;
    localparam int MCS_FARLOOP_BIT   = 9;
    localparam int MCS_ALTERNATE_INTERRUPT_SELECT_BIT    = 6;
    localparam int MCS_ENERGY_BIT    = 1;
    localparam int MCS_SPARE_BIT     = 0;

    // Special modes field positions
    localparam int SM_RSVD_ONE_BIT   = 14;
    localparam int SM_MODE_LSB       = 5;
    localparam int SM_ADDR_LSB       = 0;

    // Crossover / heartbeat / polarity field positions
    localparam int XS_AMDIX_DIS_BIT  = 15;
    localparam int XS_PAIR_SEL_BIT   = 13;
    localparam int XS_SQE_OFF_BIT    = 11;
    localparam int XS_RX_POLARITY_REVERSED_BIT       = 4;

    // Reset values
    localparam logic       RST_ENERGY_PRESENT = 1'b1;
    localparam logic       RST_RSVD_ONE       = 1'b1;
    localparam logic [15:0] RST_SYM_ERR_CNT   = 16'h0000;

    // Energy timeout
    localparam int ENERGY_TIMEOUT_MS = 256;
    localparam int CLK_HZ            = 25000000;
    localparam longint ENERGY_TIMEOUT_CYC =
        longint'(ENERGY_TIMEOUT_MS) * longint'(CLK_HZ) / 64'd1000;

    // Control fields that steer the transceiver
    typedef struct packed {
        logic       energy_detect_powerdown_en;
        logic       line_side_loopback_en;
        logic       alternate_interrupt_select;
        logic [2:0] transceiver_mode;
        logic [4:0] phy_management_address;
        logic       auto_crossover_disable;
        logic       manual_pair_select;
        logic       heartbeat_test_disable;
    } ctrl_type;

    // Line status from the receive path
    typedef struct packed {
        logic link_is_100;
        logic valid_energy;
        logic symbol_error;
        logic packet_end;
        logic rx_polarity_reversed;
    } line_status_type;

endpackage
